// ### verilog/scale_cfg_pkg.sv
// Purpose: Constants for the weighing-terminal holding-register bank
// Assumes: 50 MHz system clock, one address per 32-bit word
// Notes: Config words live in one indexed array, see CFG_* indexes
package scale_cfg_pkg;
   // Holding-register numbers
   localparam logic [15:0] ADDR_RANGE1_CAPACITY = 16'h9CDD;
   localparam logic [15:0] ADDR_RANGE1_DECIMAL_POINT = 16'h9CDF;
   localparam logic [15:0] ADDR_RANGE1_INCREMENT = 16'h9CE1;
   localparam logic [15:0] ADDR_RANGE2_CAPACITY = 16'h9CE3;
   localparam logic [15:0] ADDR_RANGE2_DECIMAL_POINT = 16'h9CE5;
   localparam logic [15:0] ADDR_RANGE2_INCREMENT = 16'h9CE7;
   localparam logic [15:0] ADDR_RANGE3_CAPACITY = 16'h9CE9;
   localparam logic [15:0] ADDR_RANGE3_DECIMAL_POINT = 16'h9CEB;
   localparam logic [15:0] ADDR_RANGE3_INCREMENT = 16'h9CED;
   localparam logic [15:0] ADDR_TARE_KIND = 16'h9CF1;
   localparam logic [15:0] ADDR_TARE_LIMIT = 16'h9CF3;
   localparam logic [15:0] ADDR_SECOND_UNIT_SELECT = 16'h9CF5;
   localparam logic [15:0] ADDR_SPARE_WORD_A = 16'h9CF7;
   localparam logic [15:0] ADDR_CALIBRATION_COMMAND = 16'h9CF9;
   localparam logic [15:0] ADDR_SPAN_REFERENCE_VALUE = 16'h9CFB;
   localparam logic [15:0] ADDR_ELECTRONIC_CALIBRATION_TOTAL_CAPACITY = 16'h9CFD;
   localparam logic [15:0] ADDR_ELECTRONIC_CALIBRATION_MV_PER_V = 16'h9CFF;
   localparam logic [15:0] ADDR_ELECTRONIC_CALIBRATION_DEAD_LOAD = 16'h9D01;
   localparam logic [15:0] ADDR_CALIBRATION_STATE_ERRORS = 16'h9D03;
   localparam logic [15:0] ADDR_SPARE_BLOCK_B_FIRST = 16'h9D05;
   localparam logic [15:0] ADDR_SPARE_BLOCK_B_LAST = 16'h9D0D;
   localparam logic [15:0] ADDR_SUPPLY_VOLTAGE_READING = 16'h9D0F;
   localparam logic [15:0] ADDR_CELL_MILLIVOLT_READING = 16'h9D11;
   localparam logic [15:0] ADDR_RESTORE_USER_PARAMS = 16'h9D13;
   localparam logic [15:0] ADDR_RESTORE_FACTORY_CONFIG = 16'h9D15;
   localparam logic [15:0] ADDR_APPLICATION_SELECT = 16'h9D3F;
   localparam logic [15:0] ADDR_LIMIT_SETTINGS = 16'h9D41;

   // Indexes into the config array; user restore covers 0..CFG_USER_N-1
   localparam int CFG_N = 18;
   localparam int CFG_USER_N = 14;
   localparam logic [4:0] CFG_R1_CAP = 5'h00;
   localparam logic [4:0] CFG_R1_DP = 5'h01;
   localparam logic [4:0] CFG_R1_INC = 5'h02;
   localparam logic [4:0] CFG_R2_CAP = 5'h03;
   localparam logic [4:0] CFG_R2_DP = 5'h04;
   localparam logic [4:0] CFG_R2_INC = 5'h05;
   localparam logic [4:0] CFG_R3_CAP = 5'h06;
   localparam logic [4:0] CFG_R3_DP = 5'h07;
   localparam logic [4:0] CFG_R3_INC = 5'h08;
   localparam logic [4:0] CFG_TARE_KIND = 5'h09;
   localparam logic [4:0] CFG_TARE_LIMIT = 5'h0A;
   localparam logic [4:0] CFG_UNIT = 5'h0B;
   localparam logic [4:0] CFG_APP = 5'h0C;
   localparam logic [4:0] CFG_LIMITS = 5'h0D;
   localparam logic [4:0] CFG_SPAN = 5'h0E;
   localparam logic [4:0] CFG_ELECTRONIC_CALIBRATION_CAP = 5'h0F;
   localparam logic [4:0] CFG_ELECTRONIC_CALIBRATION_MVV = 5'h10;
   localparam logic [4:0] CFG_ELECTRONIC_CALIBRATION_DEAD = 5'h11;

   // Values after reset or restore
   localparam logic [31:0] DEF_CAPACITY = 32'h0000_2710;
   localparam logic [31:0] DEF_DECIMAL_POINT = 32'h0000_0002;
   localparam logic [31:0] DEF_INCREMENT = 32'h0000_0000;
   localparam logic [31:0] DEF_TARE_LIMIT = 32'h0000_2710;
   localparam logic [31:0] DEF_UNIT = 32'h0000_0004;
   localparam logic [31:0] DEF_ZERO = 32'h0000_0000;

   // Highest legal code per coded field
   localparam logic [31:0] MAX_DP_CODE = 32'h0000_0005;
   localparam logic [31:0] MAX_INC_CODE = 32'h0000_0002;
   localparam logic [31:0] MAX_TARE_CODE = 32'h0000_0001;
   localparam logic [31:0] MAX_UNIT_CODE = 32'h0000_0007;
   localparam logic [31:0] MAX_APP_CODE = 32'h0000_0004;

   // Command and magic values
   localparam logic [31:0] CMD_NONE = 32'h0000_0000;
   localparam logic [31:0] CMD_ZERO_CAL = 32'h0000_00BC;
   localparam logic [31:0] CMD_SPAN_CAL = 32'h0000_00DC;
   localparam logic [31:0] CMD_ELECTRONIC_CALIBRATION_APPLY = 32'h0000_5AA5;
   localparam logic [31:0] MAGIC_USER_DEFAULTS = 32'h0000_6BB6;
   localparam logic [31:0] MAGIC_FACTORY_DEFAULTS = 32'h0000_7CC7;

   // Status bit positions
   localparam int ST_READY = 0;
   localparam int ST_ZERO_ACTIVE = 1;
   localparam int ST_SPAN_ACTIVE = 2;
   localparam int ST_TIMEOUT = 3;
   localparam int ST_FAULT_LO = 4;
   localparam int ST_SWITCH_OFF = 10;

   // Exception codes
   localparam logic [2:0] EXC_NONE = 3'h0;
   localparam logic [2:0] EXC_ADDRESS = 3'h2;
   localparam logic [2:0] EXC_VALUE = 3'h3;
   localparam logic [2:0] EXC_OPERATION = 3'h4;

   // Calibration timeout
   localparam longint CLK_HZ = 50_000_000;
   localparam longint CAL_TIMEOUT_MS = 5000;
   localparam logic [31:0] CAL_TIMEOUT_CYC =
      32'(CAL_TIMEOUT_MS * (CLK_HZ / 1000));

   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_ZERO = 3'b010,
      CAL_SPAN = 3'b100
   } cal_state_e;
endpackage : scale_cfg_pkg

// ### verilog/scale_calibration_config_regs.sv
// Purpose: Holding-register bank with calibration sequencer
// Assumes: One request per cycle at most, answered the next cycle
// Notes: Calibration side reports done or faults as single-cycle pulses, not levels
`timescale 1ns/1ps
module scale_calibration_config_regs #(
   parameter logic [31:0] TIMEOUT_CYC = scale_cfg_pkg::CAL_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [15:0] req_addr,
   input wire logic [31:0] req_wdata,
   // Register answer
   output logic resp_valid,
   output logic [31:0] resp_rdata,
   output logic [2:0] resp_exception,
   // Calibration side
   input wire logic cal_switch_on,
   input wire logic cal_done,
   input wire logic [5:0] cal_fault,
   output logic zero_cal_start,
   output logic span_cal_start,
   output logic electronic_calibration_apply,
   output logic [31:0] span_target,
   output logic [31:0] electronic_calibration_capacity,
   output logic [31:0] electronic_calibration_mv_per_v,
   output logic [31:0] electronic_calibration_dead_load,
   // Measurements
   input wire logic [31:0] supply_voltage,
   input wire logic [31:0] cell_centi_mv,
   // Settings to the weighing logic
   output logic tare_additive,
   output logic [2:0] second_unit,
   output logic [1:0] range1_fixed_zeros,
   output logic [1:0] range1_decimals,
   output logic [2:0] application_code,
   output logic user_defaults_loaded,
   output logic factory_defaults_loaded
);
   import scale_cfg_pkg::*;

   function automatic logic [31:0] cfg_default(input logic [4:0] idx);
      unique case (idx)
         CFG_R1_CAP, CFG_R2_CAP, CFG_R3_CAP: cfg_default = DEF_CAPACITY;
         CFG_R1_DP, CFG_R2_DP, CFG_R3_DP: cfg_default = DEF_DECIMAL_POINT;
         CFG_R1_INC, CFG_R2_INC, CFG_R3_INC: cfg_default = DEF_INCREMENT;
         CFG_TARE_LIMIT: cfg_default = DEF_TARE_LIMIT;
         CFG_UNIT: cfg_default = DEF_UNIT;
         default: cfg_default = DEF_ZERO;
      endcase
   endfunction : cfg_default

   // Coded fields refuse codes beyond their table
   function automatic logic value_ok(input logic [4:0] idx,
                                     input logic [31:0] d);
      unique case (idx)
         CFG_R1_DP, CFG_R2_DP, CFG_R3_DP: value_ok = d <= MAX_DP_CODE;
         CFG_R1_INC, CFG_R2_INC, CFG_R3_INC:
            value_ok = d <= MAX_INC_CODE;
         CFG_TARE_KIND: value_ok = d <= MAX_TARE_CODE;
         CFG_UNIT: value_ok = d <= MAX_UNIT_CODE;
         CFG_APP: value_ok = d <= MAX_APP_CODE;
         default: value_ok = 1'b1;
      endcase
   endfunction : value_ok

   // Returns {hit, idx}
   function automatic logic [5:0] cfg_decode(input logic [15:0] a);
      unique case (a)
         ADDR_RANGE1_CAPACITY: cfg_decode = {1'b1, CFG_R1_CAP};
         ADDR_RANGE1_DECIMAL_POINT: cfg_decode = {1'b1, CFG_R1_DP};
         ADDR_RANGE1_INCREMENT: cfg_decode = {1'b1, CFG_R1_INC};
         ADDR_RANGE2_CAPACITY: cfg_decode = {1'b1, CFG_R2_CAP};
         ADDR_RANGE2_DECIMAL_POINT: cfg_decode = {1'b1, CFG_R2_DP};
         ADDR_RANGE2_INCREMENT: cfg_decode = {1'b1, CFG_R2_INC};
         ADDR_RANGE3_CAPACITY: cfg_decode = {1'b1, CFG_R3_CAP};
         ADDR_RANGE3_DECIMAL_POINT: cfg_decode = {1'b1, CFG_R3_DP};
         ADDR_RANGE3_INCREMENT: cfg_decode = {1'b1, CFG_R3_INC};
         ADDR_TARE_KIND: cfg_decode = {1'b1, CFG_TARE_KIND};
         ADDR_TARE_LIMIT: cfg_decode = {1'b1, CFG_TARE_LIMIT};
         ADDR_SECOND_UNIT_SELECT: cfg_decode = {1'b1, CFG_UNIT};
         ADDR_APPLICATION_SELECT: cfg_decode = {1'b1, CFG_APP};
         ADDR_LIMIT_SETTINGS: cfg_decode = {1'b1, CFG_LIMITS};
         ADDR_SPAN_REFERENCE_VALUE: cfg_decode = {1'b1, CFG_SPAN};
         ADDR_ELECTRONIC_CALIBRATION_TOTAL_CAPACITY: cfg_decode = {1'b1, CFG_ELECTRONIC_CALIBRATION_CAP};
         ADDR_ELECTRONIC_CALIBRATION_MV_PER_V: cfg_decode = {1'b1, CFG_ELECTRONIC_CALIBRATION_MVV};
         ADDR_ELECTRONIC_CALIBRATION_DEAD_LOAD: cfg_decode = {1'b1, CFG_ELECTRONIC_CALIBRATION_DEAD};
         default: cfg_decode = 6'h00;
      endcase
   endfunction : cfg_decode

   // Returns {fixed_zeros, decimals}
   function automatic logic [3:0] dp_format(input logic [31:0] code);
      unique case (code[2:0])
         3'h0: dp_format = 4'h8;
         3'h1: dp_format = 4'h4;
         3'h3: dp_format = 4'h1;
         3'h4: dp_format = 4'h2;
         3'h5: dp_format = 4'h3;
         default: dp_format = 4'h0;
      endcase
   endfunction : dp_format

   logic [31:0] cfg_reg [CFG_N];
   logic [31:0] cmd_reg;
   cal_state_e state_reg, state_next;
   logic [7:0] err_reg, err_next;
   logic [31:0] tmo_reg;
   logic zero_start_reg, span_start_reg, electronic_calibration_reg;
   logic user_ld_reg, fact_ld_reg;
   logic resp_valid_reg;
   logic [31:0] rdata_reg, rdata_next;
   logic [2:0] exc_reg, exc_next;
   logic tare_reg;
   logic [2:0] unit_reg, app_reg;
   logic [3:0] dp1_reg;

   // Request decode
   wire [5:0] dec = cfg_decode(req_addr);
   wire cfg_hit = dec[5];
   wire [4:0] cfg_idx = dec[4:0];
   wire is_cmd = req_addr == ADDR_CALIBRATION_COMMAND;
   wire is_status = req_addr == ADDR_CALIBRATION_STATE_ERRORS;
   wire is_volt = req_addr == ADDR_SUPPLY_VOLTAGE_READING;
   wire is_mv = req_addr == ADDR_CELL_MILLIVOLT_READING;
   wire is_user = req_addr == ADDR_RESTORE_USER_PARAMS;
   wire is_fact = req_addr == ADDR_RESTORE_FACTORY_CONFIG;
   wire is_spare = req_addr == ADDR_SPARE_WORD_A ||
      (req_addr >= ADDR_SPARE_BLOCK_B_FIRST &&
       req_addr <= ADDR_SPARE_BLOCK_B_LAST && req_addr[0]);
   wire mapped = cfg_hit | is_cmd | is_status | is_volt | is_mv |
      is_user | is_fact | is_spare;
   wire wr = req_valid & req_write;
   wire idle = state_reg == CAL_IDLE;
   wire cmd_legal = req_wdata == CMD_NONE || req_wdata == CMD_ZERO_CAL ||
      req_wdata == CMD_SPAN_CAL || req_wdata == CMD_ELECTRONIC_CALIBRATION_APPLY;
   wire cmd_wr = wr & is_cmd & cmd_legal & idle;
   wire cal_cmd = cmd_wr &
      (req_wdata == CMD_ZERO_CAL || req_wdata == CMD_SPAN_CAL);
   wire cal_go = cal_cmd & cal_switch_on;
   wire cal_blocked = cal_cmd & ~cal_switch_on;
   wire cfg_wr = wr & cfg_hit & value_ok(cfg_idx, req_wdata);
   wire user_rst = wr & is_user & req_wdata == MAGIC_USER_DEFAULTS;
   wire fact_rst = wr & is_fact & req_wdata == MAGIC_FACTORY_DEFAULTS;
   wire timed_out = ~idle & tmo_reg >= TIMEOUT_CYC - 32'h1;
   wire fault_hit = ~idle & |cal_fault;
   wire cal_end = ~idle & (cal_done | fault_hit | timed_out);
   wire [31:0] status_word = {21'h0, err_reg,
      state_reg == CAL_SPAN, state_reg == CAL_ZERO, idle};

   // Sequencer
   always_comb begin
      state_next = state_reg;
      if (cal_go && req_wdata == CMD_ZERO_CAL) begin
         state_next = CAL_ZERO;
      end else if (cal_go) begin
         state_next = CAL_SPAN;
      end else if (cal_end) begin
         state_next = CAL_IDLE;
      end
   end

   // Errors clear on a new start; sets are ORed in afterwards
   always_comb begin
      err_next = err_reg;
      if (cal_cmd) begin
         err_next = 8'h00;
      end
      if (cal_blocked) begin
         err_next[ST_SWITCH_OFF - ST_TIMEOUT] = 1'b1;
      end
      if (timed_out && !cal_done) begin
         err_next[ST_TIMEOUT - ST_TIMEOUT] = 1'b1;
      end
      if (fault_hit) begin
         err_next[6:1] = err_next[6:1] | cal_fault;
      end
   end

   // Read data and exception
   always_comb begin
      rdata_next = 32'h0;
      exc_next = EXC_NONE;
      if (!mapped) begin
         exc_next = EXC_ADDRESS;
      end else if (req_write) begin
         if (is_status || is_volt || is_mv) begin
            exc_next = EXC_OPERATION;
         end else if (cfg_hit && !value_ok(cfg_idx, req_wdata)) begin
            exc_next = EXC_VALUE;
         end else if (is_cmd && !cmd_legal) begin
            exc_next = EXC_VALUE;
         end else if (is_cmd && !idle) begin
            exc_next = EXC_OPERATION;
         end
      end else if (cfg_hit) begin
         rdata_next = cfg_reg[cfg_idx];
      end else if (is_cmd) begin
         rdata_next = cmd_reg;
      end else if (is_status) begin
         rdata_next = status_word;
      end else if (is_volt) begin
         rdata_next = supply_voltage;
      end else if (is_mv) begin
         rdata_next = cell_centi_mv;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= CAL_IDLE;
         err_reg <= 8'h00;
         tmo_reg <= 32'h0;
      end else begin
         state_reg <= state_next;
         err_reg <= err_next;
         tmo_reg <= (idle || cal_go) ? 32'h0 : tmo_reg + 32'h1;
      end
   end

   // Config array; factory restore takes priority over a plain write
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < CFG_N; i++) begin
            cfg_reg[i] <= cfg_default(5'(i));
         end
         cmd_reg <= CMD_NONE;
      end else begin
         for (int i = 0; i < CFG_N; i++) begin
            if (fact_rst || (user_rst && i < CFG_USER_N)) begin
               cfg_reg[i] <= cfg_default(5'(i));
            end else if (cfg_wr && cfg_idx == 5'(i)) begin
               cfg_reg[i] <= req_wdata;
            end
         end
         if (fact_rst) begin
            cmd_reg <= CMD_NONE;
         end else if (cmd_wr) begin
            cmd_reg <= req_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         zero_start_reg <= 1'b0;
         span_start_reg <= 1'b0;
         electronic_calibration_reg <= 1'b0;
         user_ld_reg <= 1'b0;
         fact_ld_reg <= 1'b0;
         resp_valid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         exc_reg <= EXC_NONE;
      end else begin
         zero_start_reg <= cal_go && req_wdata == CMD_ZERO_CAL;
         span_start_reg <= cal_go && req_wdata == CMD_SPAN_CAL;
         electronic_calibration_reg <= cmd_wr && req_wdata == CMD_ELECTRONIC_CALIBRATION_APPLY;
         user_ld_reg <= user_rst;
         fact_ld_reg <= fact_rst;
         resp_valid_reg <= req_valid;
         rdata_reg <= rdata_next;
         exc_reg <= exc_next;
      end
   end

   // Decoded settings, one cycle behind the array
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tare_reg <= 1'b0;
         unit_reg <= 3'h0;
         app_reg <= 3'h0;
         dp1_reg <= 4'h0;
      end else begin
         tare_reg <= cfg_reg[CFG_TARE_KIND][0];
         unit_reg <= cfg_reg[CFG_UNIT][2:0];
         app_reg <= cfg_reg[CFG_APP][2:0];
         dp1_reg <= dp_format(cfg_reg[CFG_R1_DP]);
      end
   end

   assign resp_valid = resp_valid_reg;
   assign resp_rdata = rdata_reg;
   assign resp_exception = exc_reg;
   assign zero_cal_start = zero_start_reg;
   assign span_cal_start = span_start_reg;
   assign electronic_calibration_apply = electronic_calibration_reg;
   assign span_target = cfg_reg[CFG_SPAN];
   assign electronic_calibration_capacity = cfg_reg[CFG_ELECTRONIC_CALIBRATION_CAP];
   assign electronic_calibration_mv_per_v = cfg_reg[CFG_ELECTRONIC_CALIBRATION_MVV];
   assign electronic_calibration_dead_load = cfg_reg[CFG_ELECTRONIC_CALIBRATION_DEAD];
   assign tare_additive = tare_reg;
   assign second_unit = unit_reg;
   assign application_code = app_reg;
   assign range1_fixed_zeros = dp1_reg[3:2];
   assign range1_decimals = dp1_reg[1:0];
   assign user_defaults_loaded = user_ld_reg;
   assign factory_defaults_loaded = fact_ld_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   zero_start_a: assert property (
      req_valid && req_write && is_cmd && req_wdata == CMD_ZERO_CAL &&
      idle && cal_switch_on |=> zero_cal_start && status_word[1])
      else $error("zero command did not start zero calibration");
   span_start_a: assert property (
      req_valid && req_write && is_cmd && req_wdata == CMD_SPAN_CAL &&
      idle && cal_switch_on |=> span_cal_start && status_word[2] &&
      span_target == $past(cfg_reg[CFG_SPAN]))
      else $error("span command did not start span calibration");
   electronic_calibration_pulse_a: assert property (
      electronic_calibration_apply |-> $past(req_wdata) == CMD_ELECTRONIC_CALIBRATION_APPLY && $past(is_cmd)
      ##1 !electronic_calibration_apply)
      else $error("electronic calibration pulse without command");
   busy_flags_a: assert property (
      state_reg == CAL_ZERO |-> status_word[2:0] == 3'b010)
      else $error("zero calibration flags wrong");
   span_flags_a: assert property (
      state_reg == CAL_SPAN |-> status_word[2:0] == 3'b100)
      else $error("span calibration flags wrong");
   timeout_flag_a: assert property (
      timed_out && !cal_done |=> err_reg[0] && idle)
      else $error("timeout not flagged");
   fault_flag_a: assert property (
      !idle && cal_fault[0] |=> err_reg[1] && status_word[0])
      else $error("converter fault not flagged");
   switch_flag_a: assert property (
      req_valid && req_write && is_cmd && req_wdata == CMD_ZERO_CAL &&
      idle && !cal_switch_on |=> err_reg[7] && idle && !zero_cal_start)
      else $error("switch-off not flagged");
   user_restore_a: assert property (
      req_valid && req_write && is_user &&
      req_wdata == MAGIC_USER_DEFAULTS |=> user_defaults_loaded &&
      cfg_reg[CFG_R1_DP] == DEF_DECIMAL_POINT ##1 tare_additive == 1'b0)
      else $error("user defaults not restored");
   done_ready_a: assert property (
      !idle && cal_done |=> status_word[0] ##1 status_word[0])
      else $error("ready not restored after calibration");

   zero_done_c: cover property (zero_cal_start ##[1:20] cal_done);
   span_done_c: cover property (span_cal_start ##[1:20] cal_done);
   electronic_calibration_c: cover property (electronic_calibration_apply);
   factory_c: cover property (factory_defaults_loaded);
endmodule : scale_calibration_config_regs

// ### dv/cal_engine_model.sv
// Purpose: Calibration engine stand-in facing the register bank
// Assumes: Start pulses last one cycle
// Notes: lat 0 never answers, so the bank's own timeout must fire
`timescale 1ns/1ps
module cal_engine_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Start pulses
   input wire logic zero_cal_start,
   input wire logic span_cal_start,
   // Behaviour set by the bench
   input wire logic [15:0] lat,
   input wire logic [5:0] flt,
   // Result
   output logic cal_done,
   output logic [5:0] cal_fault
);
   logic [15:0] cnt_reg;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= 16'h0;
         cal_done <= 1'b0;
         cal_fault <= 6'h0;
      end else begin
         cal_done <= 1'b0;
         cal_fault <= 6'h0;
         if (zero_cal_start || span_cal_start) begin
            cnt_reg <= lat;
         end else if (cnt_reg == 16'h1) begin
            cnt_reg <= 16'h0;
            cal_done <= (flt == 6'h0);
            cal_fault <= flt;
         end else if (cnt_reg != 16'h0) begin
            cnt_reg <= cnt_reg - 16'h1;
         end
      end
   end
endmodule : cal_engine_model

// ### dv/test_scale_calibration_config_regs.sv
// Purpose: Self-checking bench for the holding-register bank
// Assumes: Timeout shortened to 20 cycles
// Notes: Expected words come from a local table model
`timescale 1ns/1ps
module test_scale_calibration_config_regs;
   import scale_cfg_pkg::*;
   localparam logic [31:0] ANY = 32'hFFFF_FFFF;
   localparam logic [15:0] ST = ADDR_CALIBRATION_STATE_ERRORS;
   localparam logic [15:0] CMD = ADDR_CALIBRATION_COMMAND;
   localparam logic [15:0] RA [18] = '{ADDR_RANGE1_CAPACITY,
      ADDR_RANGE1_DECIMAL_POINT, ADDR_RANGE1_INCREMENT, ADDR_RANGE2_CAPACITY,
      ADDR_RANGE3_DECIMAL_POINT, ADDR_RANGE3_INCREMENT, ADDR_TARE_KIND,
      ADDR_TARE_LIMIT, ADDR_SECOND_UNIT_SELECT, ADDR_APPLICATION_SELECT,
      ADDR_SPAN_REFERENCE_VALUE, ADDR_ELECTRONIC_CALIBRATION_DEAD_LOAD,
      ADDR_RANGE2_DECIMAL_POINT, ADDR_RANGE2_INCREMENT, ADDR_RANGE3_CAPACITY,
      ADDR_ELECTRONIC_CALIBRATION_TOTAL_CAPACITY, ADDR_ELECTRONIC_CALIBRATION_MV_PER_V, ADDR_LIMIT_SETTINGS};
   localparam logic [31:0] MX [18] = '{ANY, MAX_DP_CODE, MAX_INC_CODE, ANY,
      MAX_DP_CODE, MAX_INC_CODE, MAX_TARE_CODE, ANY, MAX_UNIT_CODE,
      MAX_APP_CODE, ANY, ANY, MAX_DP_CODE, MAX_INC_CODE, ANY, ANY, ANY, ANY};
   localparam logic [31:0] DV [18] = '{DEF_CAPACITY, DEF_DECIMAL_POINT,
      DEF_INCREMENT, DEF_CAPACITY, DEF_DECIMAL_POINT, DEF_INCREMENT, DEF_ZERO,
      DEF_TARE_LIMIT, DEF_UNIT, DEF_ZERO, DEF_ZERO, DEF_ZERO,
      DEF_DECIMAL_POINT, DEF_INCREMENT, DEF_CAPACITY, DEF_ZERO, DEF_ZERO,
      DEF_ZERO};
   logic clk_sys = 0, sys_rst = 1, req_valid = 0, req_write = 0;
   logic cal_switch_on = 1, cal_done, zs, ss, ea, ud, fd;
   logic resp_valid, zero_cal_start, span_cal_start, electronic_calibration_apply;
   logic user_defaults_loaded, factory_defaults_loaded, tare_additive;
   logic [15:0] req_addr = 0, lat = 1;
   logic [31:0] req_wdata = 0, supply_voltage = 0, cell_centi_mv = 0;
   logic [31:0] resp_rdata, span_target, electronic_calibration_capacity, electronic_calibration_mv_per_v;
   logic [31:0] electronic_calibration_dead_load, rd, d;
   logic [31:0] mv [18];
   logic [5:0] flt = 0, cal_fault;
   logic [2:0] resp_exception, second_unit, application_code;
   logic [1:0] range1_fixed_zeros, range1_decimals;
   int failures = 0, checks_done = 0, seed = 32'h76CB;
   scale_calibration_config_regs #(.TIMEOUT_CYC(32'h0000_0014))
      scale_calibration_config_regs_inst (.clk_sys, .sys_rst, .req_valid,
      .req_write, .req_addr, .req_wdata, .resp_valid, .resp_rdata,
      .resp_exception, .cal_switch_on, .cal_done, .cal_fault,
      .zero_cal_start, .span_cal_start, .electronic_calibration_apply, .span_target,
      .electronic_calibration_capacity, .electronic_calibration_mv_per_v, .electronic_calibration_dead_load, .supply_voltage,
      .cell_centi_mv, .tare_additive, .second_unit, .range1_fixed_zeros,
      .range1_decimals, .application_code, .user_defaults_loaded,
      .factory_defaults_loaded);
   cal_engine_model cal_engine_model_inst (.clk_sys, .sys_rst,
      .zero_cal_start, .span_cal_start, .lat, .flt, .cal_done, .cal_fault);
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic final_report();
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   // Extra idle edge so the strobe never rises in the step it fell
   task automatic acc(input logic w, input logic [15:0] a,
         input logic [31:0] v, input logic [2:0] ee);
      {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, v};
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      chk("resp_valid", {31'h0, resp_valid}, 32'h1);
      if (ee != 3'h7) chk("exception", {29'h0, resp_exception}, {29'h0, ee});
      rd = resp_rdata;
      {zs, ss, ea, ud, fd} = {zero_cal_start, span_cal_start, electronic_calibration_apply,
         user_defaults_loaded, factory_defaults_loaded};
      @(posedge clk_sys);
      #1;
   endtask : acc
   task automatic wr(input int i, input logic [31:0] v);
      acc(1'b1, RA[i], v, (v > MX[i]) ? EXC_VALUE : EXC_NONE);
      if (v <= MX[i]) mv[i] = v;
   endtask : wr
   task automatic rchk(input logic [15:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0, EXC_NONE);
      chk("read word", rd, e);
   endtask : rchk
   task automatic poll();
      for (int k = 0; k < 80; k++) begin
         acc(1'b0, ST, 32'h0, EXC_NONE);
         if (rd[0] === 1'b1) return;
      end
      chk("ready wait", 32'h0, 32'h1);
      final_report();
   endtask : poll
   initial begin
      mv = DV;
      repeat (8) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      rchk(ST, 32'h1);
      for (int i = 0; i < 18; i++) rchk(RA[i], mv[i]);
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 18; i++) begin
            d = $random(seed);
            wr(i, d & 32'h7);
            wr(i, d);
            rchk(RA[i], mv[i]);
         end
         chk("tare", {31'h0, tare_additive}, {31'h0, mv[6][0]});
         chk("unit", {29'h0, second_unit}, {29'h0, mv[8][2:0]});
         chk("dp", {28'h0, range1_fixed_zeros, range1_decimals},
            (mv[1] < 3) ? (32'h2 - mv[1]) << 2 : mv[1] - 32'h2);
         chk("app", {29'h0, application_code}, {29'h0, mv[9][2:0]});
      end
      acc(1'b1, ADDR_RANGE1_CAPACITY + 16'h1, 32'h5, EXC_ADDRESS);
      acc(1'b1, ST, 32'h5, EXC_OPERATION);
      supply_voltage = $random(seed);
      cell_centi_mv = $random(seed);
      rchk(ADDR_SUPPLY_VOLTAGE_READING, supply_voltage);
      rchk(ADDR_CELL_MILLIVOLT_READING, cell_centi_mv);
      acc(1'b1, ADDR_CELL_MILLIVOLT_READING, 32'h1, EXC_OPERATION);
      lat = 16'hA;
      rchk(ST, 32'h1);
      acc(1'b1, CMD, CMD_ZERO_CAL, EXC_NONE);
      chk("zero start", {31'h0, zs}, 32'h1);
      rchk(ST, 32'h2);
      acc(1'b1, CMD, CMD_SPAN_CAL, EXC_OPERATION);
      poll();
      chk("zero done", rd, 32'h1);
      cal_switch_on = 1'b0;
      acc(1'b1, CMD, CMD_ZERO_CAL, 3'h7);
      chk("no start", {31'h0, zs}, 32'h0);
      rchk(ST, 32'h401);
      cal_switch_on = 1'b1;
      lat = 16'h3;
      wr(10, 32'h1234_5678);
      for (int k = 0; k < 7; k++) begin
         flt = (k < 6) ? 6'h1 << k : 6'h0;
         acc(1'b1, CMD, CMD_SPAN_CAL, EXC_NONE);
         chk("span start", {31'h0, ss}, 32'h1);
         chk("span target", span_target, mv[10]);
         rchk(ST, 32'h4);
         poll();
         chk("span end", rd,
            32'h1 | ((32'h10 << k) & 32'h3F0));
      end
      lat = 16'h0;
      acc(1'b1, CMD, CMD_ZERO_CAL, EXC_NONE);
      poll();
      chk("timeout", rd, 32'h9);
      acc(1'b1, CMD, 32'h0000_00BD, EXC_VALUE);
      wr(11, $random(seed));
      acc(1'b1, CMD, CMD_ELECTRONIC_CALIBRATION_APPLY, EXC_NONE);
      chk("electronic_calibration pulse", {31'h0, ea}, 32'h1);
      chk("dead load", electronic_calibration_dead_load, mv[11]);
      chk("total capacity", electronic_calibration_capacity, mv[15]);
      chk("mv per v", electronic_calibration_mv_per_v, mv[16]);
      acc(1'b1, ADDR_RESTORE_USER_PARAMS, 32'h6BB7, EXC_NONE);
      chk("no restore", {31'h0, ud}, 32'h0);
      acc(1'b1, ADDR_RESTORE_USER_PARAMS, MAGIC_USER_DEFAULTS,
         EXC_NONE);
      chk("user restore", {31'h0, ud}, 32'h1);
      // Span and coefficient words survive a user restore
      for (int i = 0; i < 18; i++) begin
         if (!(i inside {10, 11, 15, 16})) mv[i] = DV[i];
      end
      for (int i = 0; i < 18; i++) rchk(RA[i], mv[i]);
      acc(1'b1, ADDR_RESTORE_FACTORY_CONFIG, MAGIC_FACTORY_DEFAULTS,
         3'h0);
      chk("factory restore", {31'h0, fd}, 32'h1);
      mv = DV;
      for (int i = 0; i < 18; i++) rchk(RA[i], mv[i]);
      final_report();
   end
endmodule : test_scale_calibration_config_regs
